// ---- hw/edge_event_pkg.sv ----
// Constants, register map and bus types of the edge event controller
package edge_event_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_LINES = 32;
    localparam int NUM_EXT_LINES = 16;
    localparam int NUM_GPIO = 86;
    localparam int NUM_PERIPH = 15;
    localparam int SEL_W = 7;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LINE_VDDIO2 = 31;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RISE_SEL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FALL_SEL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PENDING = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STAT_MASK = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_PIN_SEL0 = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_PIN_SEL3 = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_SW_TRIG = 8'h2c;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [SEL_W-1:0] RST_PIN_SEL = 7'h00;
    localparam logic [2:0] RST_STAT = 3'h0;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int STAT_NEW = 0;
    localparam int STAT_OVERRUN = 1;
    localparam int STAT_EVENT = 2;
    localparam int STAT_W = 3;

    // ------------------------------------------------------------
    // Avalon-MM request from the master
    // ------------------------------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_type;

endpackage : edge_event_pkg

// ---- hw/edge_capture.sv ----
// Clockless edge latches per line, resynchronised to core_clk
`timescale 1ns/100ps
`default_nettype none
module edge_capture #(
    parameter int WIDTH = 32
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] line_in,
    output logic [WIDTH-1:0] rise_evt,
    output logic [WIDTH-1:0] fall_evt,
    output logic [WIDTH-1:0] rise_wait,
    output logic [WIDTH-1:0] fall_wait
);
    logic [WIDTH-1:0] rise_tgl;
    logic [WIDTH-1:0] fall_tgl;
    logic [WIDTH-1:0] rise_s1_ff, rise_s2_ff, rise_s3_ff;
    logic [WIDTH-1:0] fall_s1_ff, fall_s2_ff, fall_s3_ff;

    // ------------------------------------------------------------
    // Edge latches clocked by the line itself
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_latch
        logic r_ff;
        logic f_ff;
        always_ff @(posedge line_in[i] or negedge nrst) begin
            if (!nrst) begin
                r_ff <= 1'b0;
            end else begin
                r_ff <= ~r_ff;
            end
        end
        always_ff @(negedge line_in[i] or negedge nrst) begin
            if (!nrst) begin
                f_ff <= 1'b0;
            end else begin
                f_ff <= ~f_ff;
            end
        end
        assign rise_tgl[i] = r_ff;
        assign fall_tgl[i] = f_ff;
    end

    // ------------------------------------------------------------
    // Two-stage synchronisers and toggle detection
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rise_s1_ff <= '0;
            rise_s2_ff <= '0;
            rise_s3_ff <= '0;
            fall_s1_ff <= '0;
            fall_s2_ff <= '0;
            fall_s3_ff <= '0;
        end else if (ce) begin
            rise_s1_ff <= rise_tgl;
            rise_s2_ff <= rise_s1_ff;
            rise_s3_ff <= rise_s2_ff;
            fall_s1_ff <= fall_tgl;
            fall_s2_ff <= fall_s1_ff;
            fall_s3_ff <= fall_s2_ff;
        end
    end

    always_comb begin
        rise_evt = (rise_s2_ff ^ rise_s3_ff) & {WIDTH{ce}};
        fall_evt = (fall_s2_ff ^ fall_s3_ff) & {WIDTH{ce}};
        // Edge seen but not yet handed to the core; works with clock off
        rise_wait = rise_tgl ^ rise_s2_ff;
        fall_wait = fall_tgl ^ fall_s2_ff;
    end

endmodule : edge_capture
`default_nettype wire

// ---- hw/edge_event_controller.sv ----
// Edge event controller: 32 lines, Avalon-MM registers, wake and irq
//
// Contract
// - 32 lines, each raises irq, event, wake
// - per-line rising, falling or both edges
// - per-line mask, independent of other lines
// - readable pending flag held until cleared
// - edges shorter than a clock still caught
// - sixteen lines selected from 86 pins
// - any line can wake from Stop
// - line 31 is the I/O supply comparator
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module edge_event_controller #(
    parameter int NUM_PINS = edge_event_pkg::NUM_GPIO
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire edge_event_pkg::avmm_req_type avmm_req,
    output logic [edge_event_pkg::DATA_W-1:0] avmm_readdata,
    output logic avmm_waitrequest,
    input wire logic [NUM_PINS-1:0] gpio_in,
    input wire logic [edge_event_pkg::NUM_PERIPH-1:0] periph_src,
    input wire logic vddio2_low,
    output logic [edge_event_pkg::NUM_LINES-1:0] line_irq,
    output logic [edge_event_pkg::NUM_LINES-1:0] line_evt,
    output logic wake_req,
    output logic irq
);
    import edge_event_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (NUM_PINS < 1 || NUM_PINS > (1 << SEL_W)) begin : g_bad_pins
        $error("NUM_PINS must lie between 1 and 128");
    end
    if (NUM_LINES != DATA_W ||
        LINE_VDDIO2 - NUM_EXT_LINES != NUM_PERIPH) begin : g_bad_map
        $error("line map does not fit the register layout");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] be_merge(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] new_val,
        input logic [3:0] be
    );
        logic [DATA_W-1:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        return res;
    endfunction : be_merge

    function automatic logic [DATA_W-1:0] be_mask(
        input logic [DATA_W-1:0] val,
        input logic [3:0] be
    );
        return be_merge(RST_WORD, val, be);
    endfunction : be_mask

    // Aligned word inside the pin select block
    function automatic logic is_pin_sel(
        input logic [ADDR_W-1:0] addr
    );
        return addr >= OFF_PIN_SEL0 && addr <= OFF_PIN_SEL3 &&
            addr[1:0] == 2'b00;
    endfunction : is_pin_sel

    // First line served by a pin select word
    function automatic int pin_sel_base(
        input logic [ADDR_W-1:0] addr
    );
        return 4 * int'((addr - OFF_PIN_SEL0) >> 2);
    endfunction : pin_sel_base

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DATA_W-1:0] int_mask_ff, nxt_int_mask;
    logic [DATA_W-1:0] evt_mask_ff, nxt_evt_mask;
    logic [DATA_W-1:0] rise_sel_ff, nxt_rise_sel;
    logic [DATA_W-1:0] fall_sel_ff, nxt_fall_sel;
    logic [DATA_W-1:0] pend_ff, nxt_pend;
    logic [STAT_W-1:0] stat_ff, nxt_stat;
    logic [STAT_W-1:0] stat_mask_ff, nxt_stat_mask;
    logic [SEL_W-1:0] pin_sel_ff [NUM_EXT_LINES];
    logic [SEL_W-1:0] nxt_pin_sel [NUM_EXT_LINES];
    logic ack_ff, nxt_ack;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic [DATA_W-1:0] line_irq_ff, nxt_line_irq;
    logic [DATA_W-1:0] line_evt_ff, nxt_line_evt;
    logic irq_ff, nxt_irq;
    logic wake_ff, nxt_wake;

    logic [NUM_LINES-1:0] line_raw;
    logic [NUM_LINES-1:0] rise_evt, fall_evt, rise_wait, fall_wait;
    logic [DATA_W-1:0] trig;
    logic [DATA_W-1:0] sw_trig;
    logic [DATA_W-1:0] pend_clr;
    logic [STAT_W-1:0] stat_set, stat_clr;
    logic req, wr_go, rd_go;
    logic async_wake;

    // ------------------------------------------------------------
    // Line sources
    // ------------------------------------------------------------
    always_comb begin
        line_raw = '0;
        for (int i = 0; i < NUM_EXT_LINES; i++) begin
            if (int'(pin_sel_ff[i]) < NUM_PINS) begin
                line_raw[i] = gpio_in[pin_sel_ff[i]];
            end
        end
        line_raw[LINE_VDDIO2-1:NUM_EXT_LINES] = periph_src;
        line_raw[LINE_VDDIO2] = vddio2_low;
    end

    edge_capture #(
        .WIDTH(NUM_LINES)
    ) u_capture (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .line_in(line_raw),
        .rise_evt(rise_evt),
        .fall_evt(fall_evt),
        .rise_wait(rise_wait),
        .fall_wait(fall_wait)
    );

    // ------------------------------------------------------------
    // Bus slave: one wait state, then answer
    // ------------------------------------------------------------
    assign req = avmm_req.read | avmm_req.write;
    assign wr_go = avmm_req.write & ack_ff;
    assign rd_go = avmm_req.read & ack_ff;

    always_comb begin
        nxt_ack = req & ~ack_ff;
        nxt_rdata = rdata_ff;
        // Only a read reloads read data, so it stands between reads
        if (avmm_req.read && !ack_ff) begin
            nxt_rdata = RST_WORD;
            case (avmm_req.address)
                OFF_INT_MASK: nxt_rdata = int_mask_ff;
                OFF_EVT_MASK: nxt_rdata = evt_mask_ff;
                OFF_RISE_SEL: nxt_rdata = rise_sel_ff;
                OFF_FALL_SEL: nxt_rdata = fall_sel_ff;
                OFF_PENDING: nxt_rdata = pend_ff;
                OFF_STATUS: nxt_rdata[STAT_W-1:0] = stat_ff;
                OFF_STAT_MASK: nxt_rdata[STAT_W-1:0] = stat_mask_ff;
                default: begin
                    if (is_pin_sel(avmm_req.address)) begin
                        for (int b = 0; b < 4; b++) begin
                            nxt_rdata[8*b +: SEL_W] = pin_sel_ff[
                                pin_sel_base(avmm_req.address) + b];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ack_ff <= 1'b0;
            rdata_ff <= RST_WORD;
        end else if (ce) begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign avmm_waitrequest = req & ~ack_ff;
    assign avmm_readdata = rdata_ff;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_comb begin
        nxt_int_mask = int_mask_ff;
        nxt_evt_mask = evt_mask_ff;
        nxt_rise_sel = rise_sel_ff;
        nxt_fall_sel = fall_sel_ff;
        nxt_stat_mask = stat_mask_ff;
        nxt_pin_sel = pin_sel_ff;
        if (wr_go) begin
            case (avmm_req.address)
                OFF_INT_MASK: nxt_int_mask = be_merge(int_mask_ff,
                    avmm_req.writedata, avmm_req.byteenable);
                OFF_EVT_MASK: nxt_evt_mask = be_merge(evt_mask_ff,
                    avmm_req.writedata, avmm_req.byteenable);
                OFF_RISE_SEL: nxt_rise_sel = be_merge(rise_sel_ff,
                    avmm_req.writedata, avmm_req.byteenable);
                OFF_FALL_SEL: nxt_fall_sel = be_merge(fall_sel_ff,
                    avmm_req.writedata, avmm_req.byteenable);
                OFF_STAT_MASK: begin
                    if (avmm_req.byteenable[0]) begin
                        nxt_stat_mask = avmm_req.writedata[STAT_W-1:0];
                    end
                end
                default: begin
                    if (is_pin_sel(avmm_req.address)) begin
                        for (int b = 0; b < 4; b++) begin
                            if (avmm_req.byteenable[b]) begin
                                nxt_pin_sel[pin_sel_base(avmm_req.address)
                                    + b] =
                                    avmm_req.writedata[8*b +: SEL_W];
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            int_mask_ff <= RST_WORD;
            evt_mask_ff <= RST_WORD;
            rise_sel_ff <= RST_WORD;
            fall_sel_ff <= RST_WORD;
            stat_mask_ff <= RST_STAT;
            for (int i = 0; i < NUM_EXT_LINES; i++) begin
                pin_sel_ff[i] <= RST_PIN_SEL;
            end
        end else if (ce) begin
            int_mask_ff <= nxt_int_mask;
            evt_mask_ff <= nxt_evt_mask;
            rise_sel_ff <= nxt_rise_sel;
            fall_sel_ff <= nxt_fall_sel;
            stat_mask_ff <= nxt_stat_mask;
            pin_sel_ff <= nxt_pin_sel;
        end
    end

    // ------------------------------------------------------------
    // Pending flags, forwarding, status and wake
    // ------------------------------------------------------------
    always_comb begin
        trig = (rise_evt & rise_sel_ff) | (fall_evt & fall_sel_ff);
        sw_trig = RST_WORD;
        pend_clr = RST_WORD;
        stat_clr = '0;
        if (wr_go && avmm_req.address == OFF_SW_TRIG) begin
            sw_trig = be_mask(avmm_req.writedata, avmm_req.byteenable);
        end
        if (wr_go && avmm_req.address == OFF_PENDING) begin
            pend_clr = be_mask(avmm_req.writedata, avmm_req.byteenable);
        end
        if (rd_go && avmm_req.address == OFF_STATUS) begin
            stat_clr = rdata_ff[STAT_W-1:0];
        end
        // Set beats clear in the same cycle
        nxt_pend = (pend_ff & ~pend_clr) | trig | sw_trig;
        stat_set = '0;
        stat_set[STAT_NEW] = |((trig | sw_trig) & ~pend_ff);
        stat_set[STAT_OVERRUN] = |(trig & pend_ff & ~pend_clr);
        stat_set[STAT_EVENT] = |(trig & evt_mask_ff);
        nxt_stat = (stat_ff & ~stat_clr) | stat_set;
        nxt_line_irq = nxt_pend & int_mask_ff;
        nxt_line_evt = (trig | sw_trig) & evt_mask_ff;
        nxt_irq = |(nxt_stat & stat_mask_ff);
        nxt_wake = |nxt_line_irq | |nxt_line_evt;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pend_ff <= RST_WORD;
            stat_ff <= RST_STAT;
            line_irq_ff <= RST_WORD;
            line_evt_ff <= RST_WORD;
            irq_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else if (ce) begin
            pend_ff <= nxt_pend;
            stat_ff <= nxt_stat;
            line_irq_ff <= nxt_line_irq;
            line_evt_ff <= nxt_line_evt;
            irq_ff <= nxt_irq;
            wake_ff <= nxt_wake;
        end
    end

    // Clockless wake path for Stop mode: latched edge not yet synced
    assign async_wake = |(((rise_wait & rise_sel_ff) |
        (fall_wait & fall_sel_ff)) & (int_mask_ff | evt_mask_ff));

    assign line_irq = line_irq_ff;
    assign line_evt = line_evt_ff;
    assign irq = irq_ff;
    assign wake_req = wake_ff | async_wake;

endmodule : edge_event_controller
`default_nettype wire

// ---- tb/edge_event_props.sv ----
// Checker for bus timing and line outputs of the controller
`timescale 1ns/100ps
`default_nettype none
module edge_event_props (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire edge_event_pkg::avmm_req_type avmm_req,
    input wire logic [31:0] avmm_readdata,
    input wire logic avmm_waitrequest,
    input wire logic [31:0] line_irq,
    input wire logic [31:0] line_evt,
    input wire logic wake_req,
    input wire logic irq
);
    import edge_event_pkg::*;
    logic busy;
    assign busy = avmm_req.read | avmm_req.write;
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    property p_one_wait;
        busy && avmm_waitrequest && ce |=> !avmm_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("wait state longer than one cycle");
    property p_idle_wait;
        !busy |-> !avmm_waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait)
        else $error("waitrequest without request");
    property p_wait_again;
        busy && !avmm_waitrequest && ce |=> !busy || avmm_waitrequest;
    endproperty
    a_wait_again: assert property (p_wait_again)
        else $error("back to back request not held");
    property p_rdata_hold;
        !(avmm_req.read && avmm_waitrequest) |=> $stable(avmm_readdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without read");
    property p_pend_hold;
        !$past(avmm_req.write) && !$past(avmm_req.write, 2)
            |-> ($past(line_irq) & ~line_irq) == 32'h0;
    endproperty
    a_pend_hold: assert property (p_pend_hold)
        else $error("line request dropped without write");
    property p_irq_fall;
        $fell(irq) |-> $past(busy) || $past(busy, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq fell without access");
    property p_wake;
        (|line_irq) || (|line_evt) |-> wake_req;
    endproperty
    a_wake: assert property (p_wake)
        else $error("request without wake");
    property p_evt_pulse;
        |line_evt |=> (line_evt & $past(line_evt)) == 32'h0;
    endproperty
    a_evt_pulse: assert property (p_evt_pulse)
        else $error("event longer than one cycle");
endmodule : edge_event_props
bind edge_event_controller edge_event_props u_props (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .avmm_req(avmm_req),
    .avmm_readdata(avmm_readdata), .avmm_waitrequest(avmm_waitrequest),
    .line_irq(line_irq), .line_evt(line_evt), .wake_req(wake_req),
    .irq(irq));
`default_nettype wire

// ---- tb/line_source_model.sv ----
// Pin, peripheral and supply sources with a core-side event count
`timescale 1ns/100ps
`default_nettype none
module line_source_model #(
    parameter int NUM_PINS = 86
) (
    input wire logic core_clk,
    input wire logic [31:0] line_evt,
    output var logic [NUM_PINS-1:0] gpio_in,
    output var logic [14:0] periph_src,
    output var logic vddio2_low
);
    int evt_count;
    initial begin
        gpio_in = '0;
        periph_src = '0;
        vddio2_low = 1'b0;
        evt_count = 0;
    end
    always @(posedge core_clk) begin
        if (|line_evt) evt_count <= evt_count + 1;
    end
    task automatic set_pin(input int idx, input logic v);
        @(posedge core_clk);
        gpio_in[idx] <= v;
    endtask : set_pin
    // Half-period pulse, shorter than a clock
    task automatic short_pin(input int idx);
        @(posedge core_clk);
        gpio_in[idx] <= 1'b1;
        @(negedge core_clk);
        gpio_in[idx] <= 1'b0;
    endtask : short_pin
    task automatic set_internal(input int idx, input logic v);
        @(posedge core_clk);
        if (idx == 15) vddio2_low <= v;
        else periph_src[idx] <= v;
    endtask : set_internal
endmodule : line_source_model
`default_nettype wire

// ---- tb/edge_event_controller_tb.sv ----
// Self-checking bench for the edge event controller
`timescale 1ns/100ps
`default_nettype none
module edge_event_controller_tb;
    import edge_event_pkg::*;
    logic core_clk;
    logic nrst;
    logic ce;
    avmm_req_type req;
    logic [31:0] rdat;
    logic wreq;
    logic [NUM_GPIO-1:0] gpio;
    logic [14:0] periph;
    logic vlow;
    logic [31:0] lirq;
    logic [31:0] levt;
    logic wake;
    logic irq;
    logic [31:0] d;
    int errors;
    int samples_checked;
    edge_event_controller DUT (.core_clk(core_clk), .nrst(nrst), .ce(ce),
        .avmm_req(req), .avmm_readdata(rdat), .avmm_waitrequest(wreq),
        .gpio_in(gpio), .periph_src(periph), .vddio2_low(vlow),
        .line_irq(lirq), .line_evt(levt), .wake_req(wake), .irq(irq));
    line_source_model src (.core_clk(core_clk), .line_evt(levt),
        .gpio_in(gpio), .periph_src(periph), .vddio2_low(vlow));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Single access, held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [7:0] a,
            input logic [31:0] wd);
        req.read <= rd;
        req.write <= !rd;
        req.address <= a;
        req.writedata <= wd;
        req.byteenable <= 4'hf;
        do begin
            @(posedge core_clk);
        end while (wreq !== 1'b0);
        d = rdat;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic t_reset_vals;
        for (int a = 0; a <= 'h30; a += 4) begin
            bus(1, a[7:0], '0);
            chk("reg_reset", 32'h0, d);
        end
        $display("test reset_vals done");
    endtask : t_reset_vals
    task automatic t_edges;
        bus(0, OFF_PIN_SEL0, 32'h5);
        for (int m = 1; m < 4; m++) begin
            bus(0, OFF_RISE_SEL, {31'h0, m[0]});
            bus(0, OFF_FALL_SEL, {31'h0, m[1]});
            src.set_pin(5, 1'b1);
            repeat (6) @(posedge core_clk);
            bus(1, OFF_PENDING, '0);
            chk("pend_rise", {31'h0, m[0]}, d);
            bus(0, OFF_PENDING, 32'h1);
            src.set_pin(5, 1'b0);
            repeat (6) @(posedge core_clk);
            bus(1, OFF_PENDING, '0);
            chk("pend_fall", {31'h0, m[1]}, d);
            bus(0, OFF_PENDING, 32'h1);
        end
        $display("test edges done");
    endtask : t_edges
    task automatic t_mask;
        bus(0, OFF_FALL_SEL, 32'h0);
        src.set_pin(5, 1'b1);
        repeat (6) @(posedge core_clk);
        chk("irq_masked", 32'h0, lirq);
        bus(0, OFF_PENDING, 32'h0);
        bus(1, OFF_PENDING, '0);
        chk("pend_hold", 32'h1, d);
        bus(0, OFF_INT_MASK, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("irq_unmasked", 32'h1, lirq);
        bus(0, OFF_PENDING, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("irq_cleared", 32'h0, lirq);
        src.set_pin(5, 1'b0);
        $display("test mask done");
    endtask : t_mask
    task automatic t_short;
        bus(0, OFF_PIN_SEL3, 32'h5500_0000);
        bus(0, OFF_RISE_SEL, 32'h0000_8001);
        src.short_pin(5);
        src.short_pin(85);
        repeat (6) @(posedge core_clk);
        bus(1, OFF_PENDING, '0);
        chk("pend_short", 32'h0000_8001, d);
        bus(0, OFF_PENDING, 32'hffff_ffff);
        $display("test short done");
    endtask : t_short
    task automatic t_internal;
        int c;
        c = src.evt_count;
        bus(0, OFF_RISE_SEL, 32'h8001_0000);
        bus(0, OFF_INT_MASK, 32'h8000_0000);
        bus(0, OFF_EVT_MASK, 32'h0001_0000);
        bus(0, OFF_STAT_MASK, 32'h1);
        bus(1, OFF_STATUS, '0);
        src.set_internal(15, 1'b1);
        src.set_internal(0, 1'b1);
        repeat (6) @(posedge core_clk);
        bus(1, OFF_PENDING, '0);
        chk("pend_internal", 32'h8001_0000, d);
        chk("line_irq", 32'h8000_0000, lirq);
        chk("evt_count", c + 1, src.evt_count);
        chk("irq", 32'h1, {31'h0, irq});
        chk("wake", 32'h1, {31'h0, wake});
        bus(1, OFF_STATUS, '0);
        chk("status", 32'h5, d);
        repeat (2) @(posedge core_clk);
        chk("irq_read", 32'h0, {31'h0, irq});
        $display("test internal done");
    endtask : t_internal
    task automatic t_soft;
        int c;
        c = src.evt_count;
        bus(0, OFF_SW_TRIG, 32'h0001_0002);
        bus(1, OFF_PENDING, '0);
        chk("pend_soft", 32'h8001_0002, d);
        chk("evt_soft", c + 1, src.evt_count);
        bus(1, OFF_STATUS, '0);
        chk("status_soft", 32'h1, d);
        src.set_internal(0, 1'b0);
        src.set_internal(0, 1'b1);
        repeat (6) @(posedge core_clk);
        bus(1, OFF_STATUS, '0);
        chk("status_overrun", 32'h6, d);
        chk("evt_overrun", c + 2, src.evt_count);
        chk("irq_overrun", 32'h0, {31'h0, irq});
        $display("test soft done");
    endtask : t_soft
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        errors = 0;
        samples_checked = 0;
        nrst = 1'b0;
        ce = 1'b1;
        req = '0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_reset_vals();
        t_edges();
        t_mask();
        t_short();
        t_internal();
        t_soft();
        tally_and_finish();
    end
endmodule : edge_event_controller_tb
`default_nettype wire
